// ==== core/sht_top.sv ====
// sample and hold trigger control with register slave and converter hand-off
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "sht_consts.svh"

// Notes on behaviour
// - peripheral clock: codes 4..15 give fixed delays
// - external clock: code N ends after 20+N
// - code zero ends on trigger falling edge
// - fast mode: channel 0 slot every 125us
// - normal mode: slot every 250us, triggers spaced
// - channel 1 discharge after its conversion
// - channel 0 discharge after its conversion
// - dual: own triggers; single: channel 0 trigger
// - alignment bit selects left or sign-extended right
// - channel 1 interrupt in dual mode only
// - channel 0 interrupt; single waits all enabled
// - channel 1 enable; result to location 24
// - channel 0 enable; result to location 23
// - clock select picks delay timebase
// - channel 1 soft mode ignores its pin, dual
// - soft trigger bit starts pulse, ends per code
// - channel 0 soft mode ignores pin, governs single
// - pulse high samples; fall hands to converter
// - discharge from conversion end to next rise
// - done flags: single after all, dual each
module sht_top
  import sht_pkg::*;
#(
  parameter int FAST_SLOT_CYC = `SHT_FAST_SLOT_CYC,
  parameter int NORMAL_SLOT_CYC = `SHT_NORMAL_SLOT_CYC
) (
  input wire logic clk, // peripheral clock, 25 MHz
  input wire logic nrst, // async reset, active low
  input wire logic [`SHT_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [`SHT_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic ch0_trigger_pin, // channel 0 trigger pin
  input wire logic ch1_trigger_pin, // channel 1 trigger pin
  input wire logic external_timebase_input, // external delay clock pin
  output logic ch0_sample, // channel 0 capacitors on ch0_input_pins
  output logic ch1_sample, // channel 1 capacitors on ch1_input_pins
  output logic ch0_discharge, // channel 0 pin discharge
  output logic ch1_discharge, // channel 1 pin discharge
  output logic conv_start, // one-cycle conversion request
  output logic conv_ch, // channel of the request
  output logic conv_priority, // channel 0 raised over voltage channels
  input wire sht_conv_type conv_done, // conversion result from sequencer
  output logic result_wr, // one-cycle write to adc_result_buffer
  output logic [4:0] result_addr, // result buffer location
  output logic [15:0] result_data, // formatted result
  output logic ch0_irq, // channel 0 interrupt request, level
  output logic ch1_irq // channel 1 interrupt request, level
);

  // ----------------------------------------------------------------
  // registers and pin synchronisers
  // ----------------------------------------------------------------
  sht_ctrl_type ctrl_q;
  sht_soft_type soft_q;
  logic [1:0] flag_q;
  logic [1:0] pend_q;
  logic [1:0] seen_q;
  logic [1:0] disch_q;
  logic [2:0] ext_s_q;
  logic [1:0] pin0_s_q;
  logic [1:0] pin1_s_q;
  logic ext_tick;
  logic trig0;
  logic trig1;
  logic [1:0] samp;
  logic [1:0] s_end;
  logic [1:0] t_rise;
  logic dual;
  logic [1:0] en;

  assign dual = ctrl_q.independent_trigger_mode;
  assign en = {ctrl_q.ch1_enable, ctrl_q.ch0_enable};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_s_q <= 3'h0;
      pin0_s_q <= 2'h0;
      pin1_s_q <= 2'h0;
    end else begin
      ext_s_q <= {ext_s_q[1:0], external_timebase_input};
      pin0_s_q <= {pin0_s_q[0], ch0_trigger_pin};
      pin1_s_q <= {pin1_s_q[0], ch1_trigger_pin};
    end
  end

  assign ext_tick = ext_s_q[1] & ~ext_s_q[2];

  // ----------------------------------------------------------------
  // trigger selection and pulse generators
  // ----------------------------------------------------------------
  logic src0;
  logic src1;
  assign src0 = soft_q.ch0_soft_trigger_mode ? soft_q.ch0_soft_trigger : pin0_s_q[1];
  assign src1 = soft_q.ch1_soft_trigger_mode ? soft_q.ch1_soft_trigger : pin1_s_q[1];
  assign trig0 = src0 & en[0];
  assign trig1 = (dual ? src1 : src0) & en[1];

  sht_channel u_ch0 (
    .clk(clk),
    .nrst(nrst),
    .trig(trig0),
    .ssc(ctrl_q.stop_sampling_code),
    .clk_sel(ctrl_q.clk_sel),
    .ext_tick(ext_tick),
    .sampling(samp[0]),
    .sample_end(s_end[0]),
    .trig_rise(t_rise[0])
  );

  sht_channel u_ch1 (
    .clk(clk),
    .nrst(nrst),
    .trig(trig1),
    .ssc(ctrl_q.stop_sampling_code),
    .clk_sel(ctrl_q.clk_sel),
    .ext_tick(ext_tick),
    .sampling(samp[1]),
    .sample_end(s_end[1]),
    .trig_rise(t_rise[1])
  );

  assign ch0_sample = samp[0];
  assign ch1_sample = samp[1];

  // ----------------------------------------------------------------
  // conversion slots
  // ----------------------------------------------------------------
  logic [15:0] slot_q;
  logic [15:0] slot_len;
  logic slot_tick;
  assign slot_len = ctrl_q.fast_mode ? 16'(FAST_SLOT_CYC) : 16'(NORMAL_SLOT_CYC);
  assign slot_tick = (slot_q >= slot_len - 16'h0001);
  assign conv_priority = ctrl_q.fast_mode & en[0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot_q <= 16'h0000;
    end else begin
      slot_q <= slot_tick ? 16'h0000 : slot_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 2'h0;
      conv_start <= 1'b0;
      conv_ch <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (slot_tick && pend_q[0]) begin
        conv_start <= 1'b1;
        conv_ch <= 1'b0;
      end else if (slot_tick && pend_q[1]) begin
        conv_start <= 1'b1;
        conv_ch <= 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        if (slot_tick && pend_q[i] && (i == 0 || !pend_q[0])) begin
          pend_q[i] <= 1'b0;
        end
        if (s_end[i]) begin
          pend_q[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // results, discharge and done flags
  // ----------------------------------------------------------------
  logic [13:0] raw;
  logic left;
  logic [1:0] done;
  logic [1:0] seen_n;
  logic all_done;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;

  assign raw = conv_done.data;
  assign left = conv_done.ch ? ctrl_q.ch1_result_left_justify : ctrl_q.ch0_result_left_justify;
  assign done = conv_done.valid ? (conv_done.ch ? 2'b10 : 2'b01) : 2'b00;
  assign seen_n = seen_q | done;
  assign all_done = (en != 2'b00) && ((seen_n & en) == en) && (done != 2'b00);
  assign flag_set[0] = dual ? done[0] : all_done;
  assign flag_set[1] = dual & done[1] & en[1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_wr <= 1'b0;
      result_addr <= 5'h00;
      result_data <= 16'h0000;
    end else begin
      result_wr <= conv_done.valid;
      if (conv_done.valid) begin
        result_addr <= conv_done.ch ? `SHT_RESULT_LOC1 : `SHT_RESULT_LOC0;
        result_data <= left ? {raw, 2'b00} : {raw[13], raw[13], raw};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      disch_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (t_rise[i]) begin
          disch_q[i] <= 1'b0;
        end
      end
      if (done[0] && ctrl_q.ch0_discharge_enable) begin
        disch_q[0] <= 1'b1;
      end
      if (done[1] && ctrl_q.ch1_discharge_enable) begin
        disch_q[1] <= 1'b1;
      end
    end
  end

  assign ch0_discharge = disch_q[0];
  assign ch1_discharge = disch_q[1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_q <= 2'h0;
    end else if (t_rise[0] && !dual) begin
      seen_q <= done;
    end else if (all_done) begin
      seen_q <= 2'h0;
    end else begin
      seen_q <= seen_n;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= 2'h0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set; // set wins over clear
    end
  end

  assign ch0_irq = flag_q[0] & ctrl_q.ch0_done_irq_enable;
  assign ch1_irq = flag_q[1] & ctrl_q.ch1_done_irq_enable & dual;

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic aw_q;
  logic w_q;
  logic [`SHT_ADDR_W-1:0] awaddr_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic do_wr;
  logic [15:0] stat;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] strb, input logic [15:0] msk);
    logic [15:0] bm;
    bm = {{8{strb[1]}}, {8{strb[0]}}} & msk;
    merge = (old & ~bm) | (nw & bm);
  endfunction

  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_wr = aw_q & w_q & ~s_axi_bvalid;
  assign flag_clr = (do_wr && awaddr_q == `SHT_ADDR_STAT && wstrb_q[0]) ? wdata_q[1:0] : 2'b00;
  assign stat = {8'h00, pend_q, disch_q, samp, flag_q};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SHT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata[15:0];
        wstrb_q <= s_axi_wstrb[1:0];
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == `SHT_ADDR_CTRL || awaddr_q == `SHT_ADDR_SOFT ||
                        awaddr_q == `SHT_ADDR_STAT) ? `SHT_RESP_OKAY : `SHT_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= sht_ctrl_type'(`SHT_CTRL_RESET);
      soft_q <= sht_soft_type'(`SHT_SOFT_RESET);
    end else if (do_wr && awaddr_q == `SHT_ADDR_CTRL) begin
      ctrl_q <= sht_ctrl_type'(merge(ctrl_q, wdata_q, wstrb_q, `SHT_CTRL_WMASK));
    end else if (do_wr && awaddr_q == `SHT_ADDR_SOFT) begin
      soft_q <= sht_soft_type'(merge(soft_q, wdata_q, wstrb_q, `SHT_SOFT_WMASK));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SHT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SHT_RESP_OKAY;
      unique case (s_axi_araddr)
        `SHT_ADDR_CTRL: s_axi_rdata <= {16'h0000, ctrl_q};
        `SHT_ADDR_SOFT: s_axi_rdata <= {16'h0000, soft_q};
        `SHT_ADDR_STAT: s_axi_rdata <= {16'h0000, stat};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SHT_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== core/sht_consts.svh ====
// register offsets, write masks, reset values and timing counts
`ifndef SHT_CONSTS_SVH
`define SHT_CONSTS_SVH

// ----------------------------------------------------------------
// register map (byte addresses on the register bus)
// ----------------------------------------------------------------
`define SHT_ADDR_W 4
`define SHT_ADDR_CTRL 4'h0
`define SHT_ADDR_SOFT 4'h4
`define SHT_ADDR_STAT 4'h8
`define SHT_CTRL_RESET 16'h0000
`define SHT_SOFT_RESET 16'h0000
`define SHT_CTRL_WMASK 16'hff7f
`define SHT_SOFT_WMASK 16'h0033
`define SHT_RESP_OKAY 2'b00
`define SHT_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// result buffer locations
// ----------------------------------------------------------------
`define SHT_RESULT_LOC0 5'h17
`define SHT_RESULT_LOC1 5'h18

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SHT_CLK_MHZ 25
`define SHT_CYC(ns) ((((ns) * `SHT_CLK_MHZ) + 999) / 1000)
`define SHT_T4_NS 300
`define SHT_T5_NS 350
`define SHT_T6_NS 450
`define SHT_T7_NS 550
`define SHT_T8_NS 750
`define SHT_T9_NS 1000
`define SHT_TA_NS 1500
`define SHT_TB_NS 1750
`define SHT_TC_NS 2000
`define SHT_TD_NS 2500
`define SHT_TE_NS 4000
`define SHT_TF_NS 5000
`define SHT_CODE_TIMED_MIN 4'h4
`define SHT_EXT_BASE 8'h14
`define SHT_FAST_SLOT_US 125
`define SHT_NORMAL_SLOT_US 250
`define SHT_FAST_SLOT_CYC (`SHT_FAST_SLOT_US * `SHT_CLK_MHZ)
`define SHT_NORMAL_SLOT_CYC (`SHT_NORMAL_SLOT_US * `SHT_CLK_MHZ)

`endif

// ==== core/sht_pkg.sv ====
// types shared by the sample and hold trigger control
package sht_pkg;

  typedef struct packed {
    logic [3:0] stop_sampling_code;
    logic fast_mode;
    logic ch1_discharge_enable;
    logic ch0_discharge_enable;
    logic independent_trigger_mode;
    logic reserved7;
    logic ch1_result_left_justify;
    logic ch1_done_irq_enable;
    logic ch1_enable;
    logic clk_sel;
    logic ch0_result_left_justify;
    logic ch0_done_irq_enable;
    logic ch0_enable;
  } sht_ctrl_type;

  typedef struct packed {
    logic [9:0] reserved;
    logic ch1_soft_trigger_mode;
    logic ch1_soft_trigger;
    logic [1:0] reserved2;
    logic ch0_soft_trigger_mode;
    logic ch0_soft_trigger;
  } sht_soft_type;

  typedef struct packed {
    logic valid;
    logic ch;
    logic [13:0] data;
  } sht_conv_type;

  typedef enum logic [1:0] {
    SHT_IDLE,
    SHT_SAMPLE,
    SHT_HOLD
  } sht_state_type;

endpackage

// ==== core/sht_channel.sv ====
// one sampling-pulse generator: start on trigger rise, end by edge or delay
`timescale 1ns/1ps
`include "sht_consts.svh"

module sht_channel
  import sht_pkg::*;
(
  input wire logic clk, // peripheral clock
  input wire logic nrst, // async reset, active low
  input wire logic trig, // selected trigger level
  input wire logic [3:0] ssc, // stop sampling code
  input wire logic clk_sel, // 1: delay counted in external ticks
  input wire logic ext_tick, // one-cycle pulse per external clock rise
  output logic sampling, // capacitors connected to the pins
  output logic sample_end, // one-cycle pulse when sampling stops
  output logic trig_rise // one-cycle pulse on trigger rise
);

  sht_state_type state_q;
  logic trig_q;
  logic [7:0] count_q;
  logic timed;
  logic step;
  logic [7:0] target;
  logic end_now;

  function automatic logic [7:0] delay_cycles(input logic [3:0] c);
    unique case (c)
      4'h4: delay_cycles = 8'(`SHT_CYC(`SHT_T4_NS));
      4'h5: delay_cycles = 8'(`SHT_CYC(`SHT_T5_NS));
      4'h6: delay_cycles = 8'(`SHT_CYC(`SHT_T6_NS));
      4'h7: delay_cycles = 8'(`SHT_CYC(`SHT_T7_NS));
      4'h8: delay_cycles = 8'(`SHT_CYC(`SHT_T8_NS));
      4'h9: delay_cycles = 8'(`SHT_CYC(`SHT_T9_NS));
      4'ha: delay_cycles = 8'(`SHT_CYC(`SHT_TA_NS));
      4'hb: delay_cycles = 8'(`SHT_CYC(`SHT_TB_NS));
      4'hc: delay_cycles = 8'(`SHT_CYC(`SHT_TC_NS));
      4'hd: delay_cycles = 8'(`SHT_CYC(`SHT_TD_NS));
      4'he: delay_cycles = 8'(`SHT_CYC(`SHT_TE_NS));
      4'hf: delay_cycles = 8'(`SHT_CYC(`SHT_TF_NS));
      default: delay_cycles = 8'h01;
    endcase
  endfunction

  assign trig_rise = trig & ~trig_q;
  // reserved codes with the peripheral clock fall back to edge-ended sampling
  assign timed = (ssc != 4'h0) && (clk_sel || (ssc >= `SHT_CODE_TIMED_MIN));
  assign target = clk_sel ? (`SHT_EXT_BASE + {4'h0, ssc}) : delay_cycles(ssc);
  assign step = clk_sel ? ext_tick : 1'b1;
  assign end_now = (state_q == SHT_SAMPLE) &&
                   (timed ? (step && (count_q == target - 8'h01)) : ~trig);
  assign sampling = (state_q == SHT_SAMPLE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SHT_IDLE;
      count_q <= 8'h00;
      sample_end <= 1'b0;
    end else begin
      sample_end <= end_now;
      unique case (state_q)
        SHT_IDLE: begin
          if (trig_rise) begin
            state_q <= SHT_SAMPLE;
            count_q <= 8'h00;
          end
        end
        SHT_SAMPLE: begin
          if (end_now) begin
            state_q <= trig ? SHT_HOLD : SHT_IDLE;
          end else if (timed && step) begin
            count_q <= count_q + 8'h01;
          end
        end
        SHT_HOLD: begin
          if (!trig) begin
            state_q <= SHT_IDLE;
          end
        end
        default: state_q <= SHT_IDLE;
      endcase
    end
  end

endmodule

// ==== tb/sht_checker_assertions.sv ====
// assertion checker bound to the sample and hold trigger control
`timescale 1ns/1ps
module sht_checker
  import sht_pkg::*;
#(
  parameter int FAST_SLOT_CYC = 3125,
  parameter int NORMAL_SLOT_CYC = 6250
) (
  input logic clk, // peripheral clock
  input logic nrst, // async reset, active low
  input logic ch0_sample, // channel 0 sampling
  input logic ch1_sample, // channel 1 sampling
  input logic ch0_discharge, // channel 0 discharge
  input logic ch1_discharge, // channel 1 discharge
  input logic conv_start, // conversion request
  input logic conv_ch, // channel of the request
  input sht_conv_type conv_done, // sequencer result
  input logic result_wr, // result write strobe
  input logic [4:0] result_addr, // result location
  input logic [15:0] result_data // formatted result
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_conv_single: assert property (conv_start |=> !conv_start)
    else $error("conversion request longer than one cycle");
  a_result_follows: assert property (conv_done.valid |=> result_wr)
    else $error("converted value not written to the buffer");
  a_result_loc: assert property (result_wr |-> $past(conv_done.valid) &&
    result_addr == ($past(conv_done.ch) ? 5'h18 : 5'h17))
    else $error("result written to the wrong location");
  a_result_fmt: assert property (result_wr |->
    result_data == {$past(conv_done.data), 2'b00} ||
    result_data == {{2{$past(conv_done.data[13])}}, $past(conv_done.data)})
    else $error("result neither left nor sign-extended right aligned");
  a_dis0_set: assert property ($rose(ch0_discharge) |->
    $past(conv_done.valid) && !$past(conv_done.ch))
    else $error("channel 0 discharge without its conversion");
  a_dis1_set: assert property ($rose(ch1_discharge) |->
    $past(conv_done.valid) && $past(conv_done.ch))
    else $error("channel 1 discharge without its conversion");
  a_dis0_clear: assert property ($fell(ch0_discharge) |-> ##[0:2] ch0_sample)
    else $error("channel 0 discharge ended without a new sample");
  a_dis1_clear: assert property ($fell(ch1_discharge) |-> ##[0:2] ch1_sample)
    else $error("channel 1 discharge ended without a new sample");

  c_ch1_result: cover property (result_wr && result_addr == 5'h18);
  c_dis_clear: cover property ($fell(ch0_discharge));
  c_ch1_conv: cover property (conv_start && conv_ch);
endmodule

bind sht_top sht_checker #(.FAST_SLOT_CYC(FAST_SLOT_CYC), .NORMAL_SLOT_CYC(NORMAL_SLOT_CYC))
  i_sht_checker (.clk, .nrst, .ch0_sample, .ch1_sample, .ch0_discharge, .ch1_discharge,
  .conv_start, .conv_ch, .conv_done, .result_wr, .result_addr, .result_data);

// ==== tb/sht_seq_model.sv ====
// conversion sequencer model answering each request after a chosen latency
`timescale 1ns/1ps
module sht_seq_model
  import sht_pkg::*;
#(
  parameter logic [13:0] D0 = 14'h2abc,
  parameter logic [13:0] D1 = 14'h1234
) (
  input wire logic clk, // peripheral clock
  input wire logic nrst, // async reset, active low
  input wire logic conv_start, // conversion request
  input wire logic conv_ch, // channel of the request
  input wire logic [3:0] lat, // answer latency in cycles
  output sht_conv_type conv_done // result pulse
);
  logic busy_q;
  logic ch_q;
  logic [3:0] cnt_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      ch_q <= 1'b0;
      cnt_q <= 4'h0;
      conv_done <= '0;
    end else begin
      // payload outside the valid pulse keeps changing
      conv_done <= {1'b0, ~conv_done.ch, ~conv_done.data};
      if (conv_start) begin
        busy_q <= 1'b1;
        ch_q <= conv_ch;
        cnt_q <= lat;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        conv_done <= {1'b1, ch_q, ch_q ? D1 : D0};
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// ==== tb/sht_top_tb.sv ====
// self-checking bench for the sample and hold trigger control
`timescale 1ns/1ps
`include "sht_consts.svh"
module sht_top_tb;
  import sht_pkg::*;
  localparam logic [13:0] D0 = 14'h2abc;
  localparam logic [13:0] D1 = 14'h1234;
  logic clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, ch0_sample, ch1_sample, ch0_discharge, ch1_discharge;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf, lat = 4'h9;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ch0_trigger_pin = 0, ch1_trigger_pin = 0, external_timebase_input = 0;
  logic conv_start, conv_ch, conv_priority, result_wr, ch0_irq, ch1_irq;
  logic [4:0] result_addr, raddr;
  logic [15:0] result_data, rdat;
  sht_conv_type conv_done;
  int n_errors = 0, compares = 0, run0 = 0, run1 = 0, w0 = 0, w1 = 0, nres = 0, i, n;
  int tbl[12] = '{8, 9, 12, 14, 19, 25, 38, 44, 50, 63, 100, 125};

  sht_top #(.FAST_SLOT_CYC(20), .NORMAL_SLOT_CYC(40)) i_sht_top (.*);
  sht_seq_model i_sht_seq_model (.clk, .nrst, .conv_start, .conv_ch, .lat, .conv_done);

  always #20 clk = ~clk;
  always begin
    repeat (3) @(posedge clk);
    external_timebase_input <= ~external_timebase_input;
  end
  // ----------------------------------------------------------------
  // monitors: pulse widths and last result write
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (ch0_sample) run0++; else if (run0 != 0) begin w0 = run0; run0 = 0; end
    if (ch1_sample) run1++; else if (run1 != 0) begin w1 = run1; run1 = 0; end
    if (result_wr) begin raddr = result_addr; rdat = result_data; nres++; end
  end

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin ta = 1; s_axi_awvalid <= 0; end
      if (s_axi_wvalid && s_axi_wready) begin tw = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk("rdata", {16'h0000, e}, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  // triggers spaced well beyond the normal slot period
  task pulse(input bit c, input int hold);
    if (c) ch1_trigger_pin <= 1; else ch0_trigger_pin <= 1;
    repeat (hold) @(posedge clk);
    ch0_trigger_pin <= 0;
    ch1_trigger_pin <= 0;
    repeat (400) @(posedge clk);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #1_600_000;
    n_errors++;
    $display("mismatch watchdog expected finish seen hang");
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    rd(`SHT_ADDR_CTRL, `SHT_CTRL_RESET, `SHT_RESP_OKAY);
    rd(`SHT_ADDR_SOFT, `SHT_SOFT_RESET, `SHT_RESP_OKAY);
    wr(4'hc, 16'hffff, `SHT_RESP_SLVERR);
    rd(4'hc, 16'h0000, `SHT_RESP_SLVERR);
    wr(`SHT_ADDR_CTRL, 16'hff7f, `SHT_RESP_OKAY);
    rd(`SHT_ADDR_CTRL, 16'hff7f, `SHT_RESP_OKAY);
    chk("priority", 1, conv_priority);
    wr(`SHT_ADDR_CTRL, 16'h0001, `SHT_RESP_OKAY);
    chk("priority", 0, conv_priority);
    $display("registers done");
    for (i = 4; i < 16; i++) begin
      wr(`SHT_ADDR_CTRL, {i[3:0], 12'h001}, `SHT_RESP_OKAY);
      pulse(0, 4);
      chk("width0", tbl[i-4], w0);
    end
    chk("results", 12, nres);
    chk("addr0", `SHT_RESULT_LOC0, raddr);
    chk("data0", {{2{D0[13]}}, D0}, rdat);
    for (i = 0; i < 2; i++) begin
      wr(`SHT_ADDR_CTRL, {i[3:0], 12'h001}, `SHT_RESP_OKAY);
      pulse(0, 30);
      chk("fall width", 1, w0 >= 29 && w0 <= 31);
    end
    for (i = 1; i < 16; i += 14) begin
      wr(`SHT_ADDR_CTRL, {i[3:0], 12'h009}, `SHT_RESP_OKAY);
      pulse(0, 4);
      chk("ext width", 1, w0 >= (19 + i) * 6 && w0 <= (21 + i) * 6);
    end
    $display("sampling done");
    lat <= 4'h0;
    // drop the channel 0 flag left by the single-mode sampling tests
    wr(`SHT_ADDR_STAT, 16'h0003, `SHT_RESP_OKAY);
    wr(`SHT_ADDR_CTRL, 16'h4773, `SHT_RESP_OKAY);
    w0 = 0;
    pulse(1, 4);
    chk("dual w0", 0, w0);
    chk("dual w1", 8, w1);
    chk("addr1", `SHT_RESULT_LOC1, raddr);
    chk("data1", {D1, 2'b00}, rdat);
    chk("irq1", 1, ch1_irq);
    chk("irq0", 0, ch0_irq);
    chk("dis1", 1, ch1_discharge);
    pulse(1, 4);
    pulse(0, 4);
    chk("irq0", 1, ch0_irq);
    chk("dis0", 1, ch0_discharge);
    rd(`SHT_ADDR_STAT, 16'h0033, `SHT_RESP_OKAY);
    wr(`SHT_ADDR_STAT, 16'h0003, `SHT_RESP_OKAY);
    chk("irq cleared", 0, {ch1_irq, ch0_irq});
    $display("dual done");
    wr(`SHT_ADDR_CTRL, 16'h4633, `SHT_RESP_OKAY);
    n = nres;
    pulse(1, 4);
    chk("single pin1", n, nres);
    w1 = 0;
    pulse(0, 4);
    chk("single w1", 8, w1);
    chk("single n", n + 2, nres);
    chk("single irq", 2'b01, {ch1_irq, ch0_irq});
    wr(`SHT_ADDR_STAT, 16'h0003, `SHT_RESP_OKAY);
    $display("single done");
    wr(`SHT_ADDR_CTRL, 16'h4773, `SHT_RESP_OKAY);
    wr(`SHT_ADDR_SOFT, 16'h0020, `SHT_RESP_OKAY);
    w1 = 0;
    pulse(1, 4);
    chk("soft pin", 0, w1);
    wr(`SHT_ADDR_SOFT, 16'h0030, `SHT_RESP_OKAY);
    repeat (300) @(posedge clk);
    chk("soft w1", 8, w1);
    wr(`SHT_ADDR_CTRL, 16'h4633, `SHT_RESP_OKAY);
    wr(`SHT_ADDR_SOFT, 16'h0002, `SHT_RESP_OKAY);
    w0 = 0;
    w1 = 0;
    wr(`SHT_ADDR_SOFT, 16'h0003, `SHT_RESP_OKAY);
    repeat (300) @(posedge clk);
    chk("soft both w0", 8, w0);
    chk("soft both w1", 8, w1);
    $display("soft trigger done");
    report_and_stop;
  end
endmodule
